/* src/mif_pkg.sv */
// Package of offsets, bit positions, reset values and carriers for the interrupt flag and enable block
package mif_pkg;
	// Register byte addresses
	localparam logic [11:0] MIF_OFS_CTRL = 12'h000;
	localparam logic [11:0] MIF_OFS_PEN = 12'h004;
	localparam logic [11:0] MIF_OFS_PREQ = 12'h008;
	localparam logic [11:0] MIF_OFS_PINCHG = 12'h00C;
	localparam logic [11:0] MIF_OFS_CFG = 12'h010;
	localparam logic [11:0] MIF_OFS_STAT = 12'h014;
	localparam logic [11:0] MIF_OFS_MASK = 12'h018;
	localparam logic [11:0] MIF_OFS_CORE = 12'h01C;
	// Control register bit positions
	localparam int MIF_B_GLB_EN = 7;
	localparam int MIF_B_GRP_EN = 6;
	localparam int MIF_B_T0IE = 5;
	localparam int MIF_B_EXIE = 4;
	localparam int MIF_B_PCIE = 3;
	localparam int MIF_B_T0IF = 2;
	localparam int MIF_B_EXIF = 1;
	localparam int MIF_B_PCIF = 0;
	// Peripheral enable and request bit positions
	localparam int MIF_B_ADC = 6;
	localparam int MIF_B_ACC = 4;
	localparam int MIF_B_LC = 3;
	localparam int MIF_B_T2 = 1;
	localparam logic [7:0] MIF_PERIPH_MASK = 8'h5A;
	localparam logic [7:0] MIF_CTRL_WMASK = 8'hFE;
	// Reset values
	localparam logic [7:0] MIF_RST_CTRL = 8'h00;
	localparam logic [7:0] MIF_RST_PEN = 8'h00;
	localparam logic [7:0] MIF_RST_PREQ = 8'h00;
	localparam logic [3:0] MIF_RST_PINCHG = 4'h0;
	localparam logic [3:0] MIF_RST_POST = 4'h0;
	localparam logic [1:0] MIF_RST_STAT = 2'h0;
	// Config register fields
	localparam int MIF_B_EDGE = 4;
	localparam int MIF_F_POST_LSB = 0;
	// Event status bits for the bus interrupt
	localparam int MIF_S_TAKEN = 0;
	localparam int MIF_S_RETURN = 1;
	// Interrupt vector address
	localparam logic [12:0] MIF_VECTOR = 13'h0004;

	typedef struct packed {
		logic timer0_ovf;
		logic ext_pin;
		logic [3:0] pin_change;
		logic adc_done;
		logic acc_ovf;
		logic logic_cell;
		logic timer2_match;
	} mif_events_s;

	typedef struct packed {
		logic take;
		logic ret;
	} mif_core_s;
endpackage

/* src/mif_sync3.sv */
// Three-stage synchroniser with agreement filter for a pin input
module mif_sync3 import mif_pkg::*; #(
	parameter int W = 1
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic [W-1:0] d, // Asynchronous input
	output logic [W-1:0] q // Filtered level
);
	logic [W-1:0] s1_r, s2_r, s3_r;
	logic [W-1:0] q_nxt;

	initial begin
		if (W < 1) $error("W must be at least 1");
	end

	// Output follows only when the last two stages agree
	assign q_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q <= q_nxt;
		end
	end
endmodule

/* src/mif_irq_logic.sv */
// Interrupt flag, enable and core request logic with APB register access
//
// Contract
// - Global enable gates every request to core
// - Group enable gates all peripheral requests
// - Flags set regardless of any enable
// - Timer0 overflow sets flag, enable gates
// - Valid external edge sets pin flag
// - Pin-change enable gates summary flag request
// - Summary flag read-only, OR of pin flags
// - Peripheral enables for four sources
// - Conversion finish sets adc done flag
// - Accumulator overflow sets flag, software clears
// - Logic cell rising edge sets flag
// - Timer2 flag after postscaled match count
// - Unimplemented peripheral bits read zero
// - All enables and flags reset zero
// - Taking interrupt clears global enable, vectors
// - Return sets global enable again
// - Edge select picks rising or falling
module mif_irq_logic import mif_pkg::*; #(
	parameter int PIN_CHANGE_W = 4,
	parameter int POST_W = 4
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic ext_pin, // External interrupt pin
	input wire mif_events_s events, // Same-clock event pulses
	input wire mif_core_s core, // Core take and return pulses
	output logic core_irq_req, // Request to core
	output logic core_flush, // Flush prefetch pulse
	output logic [12:0] core_vector, // Vector address
	output logic irq // Bus-side interrupt
);
	// =====================================================
	// Elaboration checks
	initial begin
		if (PIN_CHANGE_W < 1 || PIN_CHANGE_W > 4) $error("PIN_CHANGE_W out of range");
		if (POST_W < 1 || POST_W > 4) $error("POST_W out of range");
	end

	// =====================================================
	// Registers
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] pen_r, pen_nxt;
	logic [7:0] preq_r, preq_nxt;
	logic [PIN_CHANGE_W-1:0] pinchg_r, pinchg_nxt;
	logic edge_sel_r, edge_sel_nxt;
	logic [POST_W-1:0] post_r, post_nxt;
	logic [POST_W-1:0] post_cnt_r, post_cnt_nxt;
	logic [1:0] stat_r, stat_nxt;
	logic [1:0] mask_r, mask_nxt;
	logic ext_prev_r;
	logic ext_level;
	logic core_irq_nxt;
	logic [31:0] rdata_nxt;
	logic slverr_nxt;

	// =====================================================
	// Pin synchroniser
	mif_sync3 #(.W(1)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(ext_pin),
		.q(ext_level)
	);

	// =====================================================
	// Bus decode
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction

	wire acc = psel && penable && pready;
	wire wr = acc && pwrite && pstrb[0];
	wire wr_ctrl = wr && hit(paddr, MIF_OFS_CTRL);
	wire wr_pen = wr && hit(paddr, MIF_OFS_PEN);
	wire wr_preq = wr && hit(paddr, MIF_OFS_PREQ);
	wire wr_pinchg = wr && hit(paddr, MIF_OFS_PINCHG);
	wire wr_cfg = wr && hit(paddr, MIF_OFS_CFG);
	wire wr_stat = wr && hit(paddr, MIF_OFS_STAT);
	wire wr_mask = wr && hit(paddr, MIF_OFS_MASK);
	wire mapped = hit(paddr, MIF_OFS_CTRL) || hit(paddr, MIF_OFS_PEN) || hit(paddr, MIF_OFS_PREQ)
		|| hit(paddr, MIF_OFS_PINCHG) || hit(paddr, MIF_OFS_CFG) || hit(paddr, MIF_OFS_STAT)
		|| hit(paddr, MIF_OFS_MASK) || hit(paddr, MIF_OFS_CORE);
	wire [7:0] wbyte = pwdata[7:0];

	// =====================================================
	// Event detection
	wire ext_edge = edge_sel_r ? (ext_level && !ext_prev_r) : (!ext_level && ext_prev_r);
	wire ext_set = ext_edge;
	wire t0_set = events.timer0_ovf;
	wire adc_set = events.adc_done;
	wire acc_set = events.acc_ovf;
	wire lc_set = events.logic_cell;
	wire post_done = post_cnt_r == post_r;
	wire t2_set = events.timer2_match && post_done;
	wire [POST_W-1:0] post_cnt_inc = post_cnt_r + 1'b1;
	assign post_cnt_nxt = wr_cfg ? '0 : (events.timer2_match ? (post_done ? '0 : post_cnt_inc) : post_cnt_r);

	// Per-pin flags: set wins over the software clear
	assign pinchg_nxt = (wr_pinchg ? (pinchg_r & wbyte[PIN_CHANGE_W-1:0]) : pinchg_r)
		| events.pin_change[PIN_CHANGE_W-1:0];
	wire pc_summary = |pinchg_r;

	// =====================================================
	// Control register
	wire take = core.take && ctrl_r[MIF_B_GLB_EN];
	wire [7:0] ctrl_wr = wr_ctrl ? ((wbyte & MIF_CTRL_WMASK) | (ctrl_r & ~MIF_CTRL_WMASK)) : ctrl_r;
	wire [7:0] ctrl_set = {5'h00, t0_set, ext_set, 1'b0} << 0;
	wire glb_en_nxt = take ? 1'b0 : (core.ret ? 1'b1 : ctrl_wr[MIF_B_GLB_EN]);
	always_comb begin
		ctrl_nxt = ctrl_wr | ctrl_set;
		ctrl_nxt[MIF_B_GLB_EN] = glb_en_nxt;
		ctrl_nxt[MIF_B_PCIF] = pc_summary;
	end

	// =====================================================
	// Peripheral registers
	assign pen_nxt = (wr_pen ? wbyte : pen_r) & MIF_PERIPH_MASK;
	wire [7:0] preq_set = {1'b0, adc_set, 1'b0, acc_set, lc_set, 1'b0, t2_set, 1'b0};
	assign preq_nxt = ((wr_preq ? wbyte : preq_r) | preq_set) & MIF_PERIPH_MASK;

	assign edge_sel_nxt = wr_cfg ? wbyte[MIF_B_EDGE] : edge_sel_r;
	assign post_nxt = wr_cfg ? wbyte[MIF_F_POST_LSB +: POST_W] : post_r;

	// =====================================================
	// Request combination
	wire core_pairs = (ctrl_r[MIF_B_T0IE] && ctrl_r[MIF_B_T0IF])
		|| (ctrl_r[MIF_B_EXIE] && ctrl_r[MIF_B_EXIF])
		|| (ctrl_r[MIF_B_PCIE] && pc_summary);
	wire periph_pairs = |(pen_r & preq_r & MIF_PERIPH_MASK);
	wire group_req = ctrl_r[MIF_B_GRP_EN] && periph_pairs;
	assign core_irq_nxt = ctrl_nxt[MIF_B_GLB_EN] && ctrl_r[MIF_B_GLB_EN] && !take
		&& (core_pairs || group_req);

	// =====================================================
	// Bus-side event status and interrupt
	wire [1:0] stat_evt = {core.ret, take};
	assign stat_nxt = (wr_stat ? (stat_r & ~wbyte[1:0]) : stat_r) | stat_evt;
	assign mask_nxt = wr_mask ? wbyte[1:0] : mask_r;

	// =====================================================
	// Read data
	wire [7:0] ctrl_rd = {ctrl_r[7:1], pc_summary};
	wire [7:0] core_rd = {6'h00, ctrl_r[MIF_B_GLB_EN], core_irq_req};
	assign rdata_nxt = !(psel && !penable && !pwrite) ? prdata :
		hit(paddr, MIF_OFS_CTRL) ? {24'h000000, ctrl_rd} :
		hit(paddr, MIF_OFS_PEN) ? {24'h000000, pen_r & MIF_PERIPH_MASK} :
		hit(paddr, MIF_OFS_PREQ) ? {24'h000000, preq_r & MIF_PERIPH_MASK} :
		hit(paddr, MIF_OFS_PINCHG) ? {{(32-PIN_CHANGE_W){1'b0}}, pinchg_r} :
		hit(paddr, MIF_OFS_CFG) ? {27'h0000000, edge_sel_r, {(4-POST_W){1'b0}}, post_r} :
		hit(paddr, MIF_OFS_STAT) ? {30'h00000000, stat_r} :
		hit(paddr, MIF_OFS_MASK) ? {30'h00000000, mask_r} :
		hit(paddr, MIF_OFS_CORE) ? {24'h000000, core_rd} : 32'h00000000;
	assign slverr_nxt = psel && !penable && !mapped;

	// =====================================================
	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= MIF_RST_CTRL;
			pen_r <= MIF_RST_PEN;
			preq_r <= MIF_RST_PREQ;
			pinchg_r <= '0;
			edge_sel_r <= 1'b0;
			post_r <= '0;
			post_cnt_r <= '0;
			stat_r <= MIF_RST_STAT;
			mask_r <= MIF_RST_STAT;
			ext_prev_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			pen_r <= pen_nxt;
			preq_r <= preq_nxt;
			pinchg_r <= pinchg_nxt;
			edge_sel_r <= edge_sel_nxt;
			post_r <= post_nxt;
			post_cnt_r <= post_cnt_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			ext_prev_r <= ext_level;
		end
	end

	// Outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			core_irq_req <= 1'b0;
			core_flush <= 1'b0;
			core_vector <= 13'h0000;
			irq <= 1'b0;
		end else begin
			prdata <= rdata_nxt;
			pready <= psel && !penable;
			pslverr <= slverr_nxt;
			core_irq_req <= core_irq_nxt;
			core_flush <= take;
			core_vector <= MIF_VECTOR;
			irq <= |(stat_nxt & mask_nxt);
		end
	end
endmodule

/* testbench/mif_irq_logic_properties.sv */
// Port checker of the interrupt flag and enable block
module mif_irq_props import mif_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire mif_core_s core, // Core pulses
	input wire logic core_irq_req, // Request
	input wire logic core_flush, // Flush
	input wire logic [12:0] core_vector // Vector
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_unmapped: assert property (pslverr |-> pready && paddr > 12'h01C)
		else $error("error on mapped address");
	chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved without setup");
	chk_flush_take: assert property (core.take |=> core_flush)
		else $error("no flush after take");
	chk_flush_cause: assert property (core_flush |-> $past(core.take))
		else $error("flush without take");
	chk_vector_fix: assert property (core_flush |-> core_vector == MIF_VECTOR)
		else $error("wrong vector");
	chk_req_drop: assert property (core.take |=> !core_irq_req [*2])
		else $error("request held after take");
	cover property (core_flush);
	cover property (core.ret);
	cover property (pready && pslverr);
endmodule

/* testbench/mif_core_model.sv */
// Core sequencer model: takes one request when armed, returns later
module mif_core_model import mif_pkg::*; #(
	parameter int DLY = 40
) (
	input wire logic pclk, // Clock
	input wire logic arm, // Allow one take
	input wire logic core_irq_req, // Request
	output mif_core_s core // Take and return pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		core = '0;
		forever begin
			@(posedge pclk);
			if (arm && core_irq_req) begin
				core.take <= 1'b1;
				@(posedge pclk);
				core.take <= 1'b0;
				repeat (DLY) @(posedge pclk);
				core.ret <= 1'b1;
				@(posedge pclk);
				core.ret <= 1'b0;
				wait (!arm);
			end
		end
	end
endmodule

/* testbench/tb_mif_irq_logic.sv */
// Self-checking bench of the interrupt flag and enable block
module tb_mif_irq_logic import mif_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [9:0] e; logic [7:0] c; logic [7:0] p; logic [11:0] a; logic [7:0] f; logic q;} mif_row_s;
	localparam mif_row_s ROWS [10] = '{
		'{10'h200, 8'hA0, 8'h00, 12'h000, 8'h04, 1'b1},
		'{10'h200, 8'h20, 8'h00, 12'h000, 8'h04, 1'b0},
		'{10'h008, 8'hC0, 8'h40, 12'h008, 8'h40, 1'b1},
		'{10'h008, 8'h80, 8'h40, 12'h008, 8'h40, 1'b0},
		'{10'h004, 8'hC0, 8'h10, 12'h008, 8'h10, 1'b1},
		'{10'h002, 8'hC0, 8'h08, 12'h008, 8'h08, 1'b1},
		'{10'h001, 8'hC0, 8'h02, 12'h008, 8'h02, 1'b1},
		'{10'h010, 8'h88, 8'h00, 12'h000, 8'h01, 1'b1},
		'{10'h010, 8'h80, 8'h00, 12'h000, 8'h01, 1'b0},
		'{10'h008, 8'hC0, 8'h10, 12'h008, 8'h40, 1'b0}};
	logic pclk, presetn, psel, penable, pwrite, ext_pin, pready, pslverr, core_irq_req, core_flush, irq, arm, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [12:0] core_vector;
	mif_events_s ev;
	mif_core_s core;
	int fails = 0;
	int cmp_count = 0;
	mif_irq_logic uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_pin(ext_pin), .events(ev), .core(core), .core_irq_req(core_irq_req), .core_flush(core_flush),
		.core_vector(core_vector), .irq(irq));
	mif_core_model #(.DLY(40)) u_core (.pclk(pclk), .arm(arm), .core_irq_req(core_irq_req), .core(core));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		check(rd, e);
	endtask
	task automatic pulse(input logic [9:0] e);
		ev <= e;
		@(posedge pclk);
		ev <= '0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic zero_chk();
		for (int k = 0; k < 3; k++) rd_chk(12'(k * 4), '0);
	endtask
	task automatic results();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// Stimulus
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#80000;
		fails++;
		results();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		ext_pin = 1'b0;
		ev = '0;
		arm = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		zero_chk();
		foreach (ROWS[i]) begin
			for (int k = 0; k < 4; k++) apb(1'b1, 12'(k * 4), '0);
			apb(1'b1, MIF_OFS_PEN, {24'h0, ROWS[i].p});
			apb(1'b1, MIF_OFS_CTRL, {24'h0, ROWS[i].c});
			pulse(ROWS[i].e);
			check({31'h0, core_irq_req}, {31'h0, ROWS[i].q});
			apb(1'b0, ROWS[i].a, '0);
			check(rd & {24'h0, ROWS[i].f}, {24'h0, ROWS[i].f});
		end
		apb(1'b1, MIF_OFS_PEN, 32'hFF);
		rd_chk(MIF_OFS_PEN, 32'h5A);
		apb(1'b1, MIF_OFS_PREQ, 32'hFF);
		rd_chk(MIF_OFS_PREQ, 32'h5A);
		apb(1'b1, MIF_OFS_CTRL, 32'h3F);
		rd_chk(MIF_OFS_CTRL, 32'h3E);
		apb(1'b1, MIF_OFS_CTRL, 32'h0);
		pulse(10'h030);
		rd_chk(MIF_OFS_CTRL, 32'h1);
		apb(1'b1, MIF_OFS_PINCHG, 32'h2);
		rd_chk(MIF_OFS_CTRL, 32'h1);
		apb(1'b1, MIF_OFS_PINCHG, 32'h0);
		rd_chk(MIF_OFS_CTRL, 32'h0);
		apb(1'b1, MIF_OFS_CFG, 32'h2);
		apb(1'b1, MIF_OFS_PREQ, 32'h0);
		for (int k = 0; k < 3; k++) begin
			pulse(10'h001);
			rd_chk(MIF_OFS_PREQ, (k == 2) ? 32'h2 : 32'h0);
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, MIF_OFS_CFG, (k < 2) ? 32'h10 : 32'h0);
			apb(1'b1, MIF_OFS_CTRL, 32'h0);
			ext_pin <= ~ext_pin;
			repeat (8) @(posedge pclk);
			rd_chk(MIF_OFS_CTRL, (k == 0 || k == 3) ? 32'h2 : 32'h0);
		end
		rd_chk(12'h020, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, MIF_OFS_STAT, 32'h3);
		apb(1'b1, MIF_OFS_CTRL, 32'hA0);
		pulse(10'h200);
		arm <= 1'b1;
		for (int n = 0; n < 20 && core_flush !== 1'b1; n++) @(posedge pclk);
		arm <= 1'b0;
		check({19'h0, core_vector}, {19'h0, MIF_VECTOR});
		rd_chk(MIF_OFS_CORE, 32'h0);
		rd_chk(MIF_OFS_STAT, 32'h1);
		apb(1'b1, MIF_OFS_MASK, 32'h1);
		rd_chk(MIF_OFS_STAT, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, MIF_OFS_STAT, 32'h1);
		rd_chk(MIF_OFS_STAT, 32'h0);
		check({31'h0, irq}, 32'h0);
		repeat (40) @(posedge pclk);
		rd_chk(MIF_OFS_CORE, 32'h3);
		rd_chk(MIF_OFS_STAT, 32'h2);
		check({31'h0, irq}, 32'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		zero_chk();
		results();
	end
endmodule
bind mif_irq_logic mif_irq_props u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
	.core_irq_req(core_irq_req), .core_flush(core_flush), .core_vector(core_vector));
